// ===== supply_cmd.sv
// Remote command interpreter of a bipolar supply: decoded program and query
// messages arrive on a strobed port and steer setpoints, presets, setup files,
// the trigger buffer and protection settings.
// Assumes one 20 MHz clock; mode, measurements, hardware limits and the limit
// event come from the analog side and are synchronised here.
`timescale 1ns/10ps

module supply_cmd
   import supply_cmd_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_b_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic              cc_mode_i,
   input  wire logic              limit_event_i,
   input  wire logic [DATA_W-1:0] meas_v_i,
   input  wire logic [DATA_W-1:0] meas_i_i,
   input  wire logic [DATA_W-1:0] hw_pos_vlim_i,
   input  wire logic [DATA_W-1:0] hw_neg_vlim_i,
   input  wire logic [DATA_W-1:0] hw_pos_ilim_i,
   input  wire logic [DATA_W-1:0] hw_neg_ilim_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic                   err_o,
   output logic      [7:0]        err_code_o,
   output logic                   out_en_o,
   output logic                   power_off_o,
   output logic                   alarm_o,
   output logic      [DATA_W-1:0] v_set_o,
   output logic      [DATA_W-1:0] i_set_o,
   output logic      [7:0]        fine_v_o,
   output logic      [7:0]        fine_i_o,
   output logic      [12:0]       slew_us_o,
   output logic      [DATA_W-1:0] pos_vlim_o,
   output logic      [DATA_W-1:0] neg_vlim_o,
   output logic      [DATA_W-1:0] pos_ilim_o,
   output logic      [DATA_W-1:0] neg_ilim_o,
   output logic      [1:0]        ovp_mode_o,
   output logic      [9:0]        limit_delay_o,
   output logic                   bus_prot_en_o
);

   // Inputs from the analog side, sampled as one group
   typedef struct packed {
      logic        cc;
      logic        ev;
      val_type     mv;
      val_type     mi;
      val_type     hpv;
      val_type     hnv;
      val_type     hpi;
      val_type     hni;
   } pins_type;

   // All state of the block
   typedef struct packed {
      pins_type                     p1;
      pins_type                     p2;
      logic                         ev_prev;
      setup_type                    cfg;
      logic                         out_en;
      logic                         alarm;
      logic                         power_off;
      logic                         trig_full;
      logic                         trig_is_v;
      val_type                      trig_val;
      logic [NUM_PRESETS-1:0][DATA_W-1:0] pre_v;
      logic [NUM_PRESETS-1:0][DATA_W-1:0] pre_i;
      setup_type [NUM_SETUPS-1:0]   files;
      logic [DATA_W-1:0]            rdata;
      logic                         err;
      logic [7:0]                   err_code;
      logic [12:0]                  slew_us;
      logic                         bus_prot_en;
   } state_type;

   localparam state_type RESET_STATE = '{
      p1: '0, p2: '0, ev_prev: 1'b0, cfg: FACTORY_SETUP, out_en: 1'b0,
      alarm: 1'b0, power_off: 1'b0, trig_full: 1'b0, trig_is_v: 1'b0,
      trig_val: '0, pre_v: '0, pre_i: '0, files: {NUM_SETUPS{FACTORY_SETUP}},
      rdata: '0, err: 1'b0, err_code: ERR_NONE, slew_us: SLEW_NONE_US,
      bus_prot_en: (FACTORY_SETUP.bus_prot == BUS_PROT_ON)};

   state_type st_r;
   state_type st_nxt;

   // Range check on a signed argument
   function automatic logic in_rng(input val_type a, input int lo, input int hi);
      in_rng = (int'(a) >= lo) && (int'(a) <= hi);
   endfunction

   // Slew code to time in microseconds
   function automatic logic [12:0] slew_time(input logic [2:0] code, input logic cc);
      unique case (code)
         SLEW_FAST: slew_time = cc ? SLEW_FAST_CC_US : SLEW_FAST_US;
         SLEW_MID:  slew_time = SLEW_MID_US;
         SLEW_SLOW: slew_time = SLEW_SLOW_US;
         default:   slew_time = SLEW_NONE_US;
      endcase
   endfunction

   // Sign extension of a fine value for the answer port
   function automatic logic [DATA_W-1:0] sext8(input logic [7:0] f);
      sext8 = {{(DATA_W-8){f[7]}}, f};
   endfunction

   // Next state: synchronisers, command decode, queries and protection
   always_comb begin
      logic      cc;
      logic      ev_rise;
      val_type   arg;
      logic [1:0] pslot;
      logic [3:0] sidx;
      cc      = st_r.p2.cc;
      ev_rise = st_r.p2.ev && !st_r.ev_prev;
      arg     = val_type'(wdata_i);
      pslot   = 2'(wdata_i - DATA_W'(PRESET_MIN));
      sidx    = wdata_i[3:0];

      st_nxt          = st_r;
      st_nxt.p1       = '{cc: cc_mode_i, ev: limit_event_i, mv: meas_v_i, mi: meas_i_i,
                          hpv: hw_pos_vlim_i, hnv: hw_neg_vlim_i, hpi: hw_pos_ilim_i, hni: hw_neg_ilim_i};
      st_nxt.p2       = st_r.p1;
      st_nxt.ev_prev  = st_r.p2.ev;
      st_nxt.rdata    = '0;
      st_nxt.err      = 1'b0;
      st_nxt.err_code = ERR_NONE;

      // Any command except execute drops a loaded buffer
      if ((wr_i && addr_i != CMD_BUF_EXEC) || rd_i) begin
         st_nxt.trig_full = 1'b0;
      end

      // Program messages
      if (wr_i) begin
         unique case (addr_i)
            CMD_OUTPUT: begin
               if (in_rng(arg, 0, 1)) begin
                  st_nxt.out_en = wdata_i[0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_VOLT_SET: st_nxt.cfg.v_set = arg;
            CMD_CURR_SET: st_nxt.cfg.i_set = arg;
            CMD_FINE_VOLT: begin
               if (!cc && in_rng(arg, FINE_MIN, FINE_MAX)) begin
                  st_nxt.cfg.fine_v = wdata_i[7:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_FINE_CURR: begin
               if (cc && in_rng(arg, FINE_MIN, FINE_MAX)) begin
                  st_nxt.cfg.fine_i = wdata_i[7:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_SLEW_TIME: begin
               if (in_rng(arg, SLEW_MIN, SLEW_MAX)) begin
                  st_nxt.cfg.slew = wdata_i[2:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_BUF_VOLT: begin
               if (!cc) begin
                  st_nxt.trig_full = 1'b1;
                  st_nxt.trig_is_v = 1'b1;
                  st_nxt.trig_val  = arg;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_BUF_CURR: begin
               if (cc) begin
                  st_nxt.trig_full = 1'b1;
                  st_nxt.trig_is_v = 1'b0;
                  st_nxt.trig_val  = arg;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_BUF_CLEAR: st_nxt.trig_full = 1'b0;
            CMD_BUF_EXEC: begin
               // Empty buffer: no effect; fine values are left alone
               if (st_r.trig_full) begin
                  if (st_r.trig_is_v) begin
                     st_nxt.cfg.v_set = st_r.trig_val;
                  end else begin
                     st_nxt.cfg.i_set = st_r.trig_val;
                  end
                  st_nxt.trig_full = 1'b0;
               end
            end
            CMD_PRESET_RCL: begin
               if (in_rng(arg, PRESET_MIN, PRESET_MAX)) begin
                  st_nxt.cfg.v_set = st_r.pre_v[pslot];
                  st_nxt.cfg.i_set = st_r.pre_i[pslot];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_PRESET_STO: begin
               if (in_rng(arg, PRESET_MIN, PRESET_MAX)) begin
                  st_nxt.pre_v[pslot] = st_r.cfg.v_set;
                  st_nxt.pre_i[pslot] = st_r.cfg.i_set;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_SETUP_RCL: begin
               if (in_rng(arg, SETUP_MIN, SETUP_MAX)) begin
                  st_nxt.cfg = st_r.files[sidx];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_SETUP_STO: begin
               if (in_rng(arg, SETUP_MIN, SETUP_MAX)) begin
                  st_nxt.files[sidx] = st_r.cfg;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_FACTORY: st_nxt.cfg = FACTORY_SETUP;
            CMD_ALARM_RESET: begin
               st_nxt.alarm     = 1'b0;
               st_nxt.power_off = 1'b0;
            end
            CMD_POS_VLIM: st_nxt.cfg.pos_vlim = arg;
            CMD_NEG_VLIM: st_nxt.cfg.neg_vlim = arg;
            CMD_POS_ILIM: st_nxt.cfg.pos_ilim = arg;
            CMD_NEG_ILIM: st_nxt.cfg.neg_ilim = arg;
            CMD_LIMIT_ACTION: begin
               if (in_rng(arg, 1, 2)) begin
                  st_nxt.cfg.lim_act = wdata_i[1:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_OVP_MODE: begin
               if (in_rng(arg, OVP_MIN, OVP_MAX)) begin
                  st_nxt.cfg.ovp = wdata_i[1:0];
               end else if (int'(arg) == OVP_CROWBAR) begin
                  st_nxt.err      = 1'b1;
                  st_nxt.err_code = ERR_CANT_EXEC;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_LIMIT_DELAY: begin
               if (in_rng(arg, LIM_DLY_MIN, LIM_DLY_MAX)) begin
                  st_nxt.cfg.delay = wdata_i[9:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            CMD_BUS_PROT: begin
               if (in_rng(arg, 1, 2)) begin
                  st_nxt.cfg.bus_prot = wdata_i[1:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            default: st_nxt.err = 1'b1;
         endcase
      end

      // Query messages, answered in the next cycle
      if (rd_i) begin
         unique case (addr_i)
            CMD_OUTPUT:       st_nxt.rdata = DATA_W'(st_r.out_en);
            CMD_VOLT_SET:     st_nxt.rdata = st_r.cfg.v_set;
            CMD_CURR_SET:     st_nxt.rdata = st_r.cfg.i_set;
            CMD_VOLT_MEAS:    st_nxt.rdata = st_r.p2.mv;
            CMD_CURR_MEAS:    st_nxt.rdata = st_r.p2.mi;
            CMD_FINE_VOLT:    st_nxt.rdata = sext8(st_r.cfg.fine_v);
            CMD_FINE_CURR:    st_nxt.rdata = sext8(st_r.cfg.fine_i);
            CMD_SLEW_TIME:    st_nxt.rdata = DATA_W'(st_r.cfg.slew);
            CMD_POS_VLIM:     st_nxt.rdata = st_r.cfg.pos_vlim;
            CMD_NEG_VLIM:     st_nxt.rdata = st_r.cfg.neg_vlim;
            CMD_POS_ILIM:     st_nxt.rdata = st_r.cfg.pos_ilim;
            CMD_NEG_ILIM:     st_nxt.rdata = st_r.cfg.neg_ilim;
            CMD_HW_POS_VLIM:  st_nxt.rdata = st_r.p2.hpv;
            CMD_HW_NEG_VLIM:  st_nxt.rdata = st_r.p2.hnv;
            CMD_HW_POS_ILIM:  st_nxt.rdata = st_r.p2.hpi;
            CMD_HW_NEG_ILIM:  st_nxt.rdata = st_r.p2.hni;
            CMD_LIMIT_ACTION: st_nxt.rdata = DATA_W'(st_r.cfg.lim_act);
            CMD_OVP_MODE:     st_nxt.rdata = DATA_W'(st_r.cfg.ovp);
            CMD_LIMIT_DELAY:  st_nxt.rdata = DATA_W'(st_r.cfg.delay);
            CMD_BUS_PROT:     st_nxt.rdata = DATA_W'(st_r.cfg.bus_prot);
            default: begin
               st_nxt.err      = 1'b1;
               st_nxt.err_code = ERR_REFUSED;
            end
         endcase
      end

      // Generic refusal code unless a specific one was chosen
      if (st_nxt.err && st_nxt.err_code == ERR_NONE) begin
         st_nxt.err_code = ERR_REFUSED;
      end

      // Limit event after the command so it wins over an alarm reset
      if (ev_rise) begin
         st_nxt.alarm = 1'b1;
         if (st_r.cfg.lim_act == ACT_PWR_OFF) begin
            st_nxt.power_off = 1'b1;
         end else begin
            st_nxt.out_en = 1'b0;
         end
      end

      // Slew time follows the new code and the present regulation mode
      st_nxt.slew_us = slew_time(st_nxt.cfg.slew, cc);
      // Bus protection enable kept in a flop so the pin has no decode behind it
      st_nxt.bus_prot_en = (st_nxt.cfg.bus_prot == BUS_PROT_ON);
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata_o       = st_r.rdata;
   assign err_o         = st_r.err;
   assign err_code_o    = st_r.err_code;
   assign out_en_o      = st_r.out_en;
   assign power_off_o   = st_r.power_off;
   assign alarm_o       = st_r.alarm;
   assign v_set_o       = st_r.cfg.v_set;
   assign i_set_o       = st_r.cfg.i_set;
   assign fine_v_o      = st_r.cfg.fine_v;
   assign fine_i_o      = st_r.cfg.fine_i;
   assign slew_us_o     = st_r.slew_us;
   assign pos_vlim_o    = st_r.cfg.pos_vlim;
   assign neg_vlim_o    = st_r.cfg.neg_vlim;
   assign pos_ilim_o    = st_r.cfg.pos_ilim;
   assign neg_ilim_o    = st_r.cfg.neg_ilim;
   assign ovp_mode_o    = st_r.cfg.ovp;
   assign limit_delay_o = st_r.cfg.delay;
   assign bus_prot_en_o = st_r.bus_prot_en;

endmodule

// ===== supply_cmd_pkg.sv
// Package: command codes, field layouts, factory defaults and timing figures
// for the supply remote command interpreter.
// Assumes a front end has already parsed the ASCII messages into a command
// code and a signed 16-bit argument in fixed engineering units.
package supply_cmd_pkg;

   // Port widths
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   typedef logic signed [DATA_W-1:0] val_type;
   typedef logic        [ADDR_W-1:0] cmd_type;

   // Command codes, the address seen on the register port
   localparam cmd_type CMD_OUTPUT       = 5'h00;
   localparam cmd_type CMD_VOLT_SET     = 5'h01; // voltage_setpoint_cmd
   localparam cmd_type CMD_CURR_SET     = 5'h02; // current_setpoint_cmd
   localparam cmd_type CMD_VOLT_MEAS    = 5'h03;
   localparam cmd_type CMD_CURR_MEAS    = 5'h04;
   localparam cmd_type CMD_FINE_VOLT    = 5'h05; // fine_voltage_cmd
   localparam cmd_type CMD_FINE_CURR    = 5'h06; // fine_current_cmd
   localparam cmd_type CMD_SLEW_TIME    = 5'h07; // slew_time_cmd
   localparam cmd_type CMD_BUF_VOLT     = 5'h08; // buffered_voltage_cmd
   localparam cmd_type CMD_BUF_CURR     = 5'h09; // buffered_current_cmd
   localparam cmd_type CMD_BUF_CLEAR    = 5'h0a; // buffer_clear_cmd
   localparam cmd_type CMD_BUF_EXEC     = 5'h0b; // buffer_execute_cmd
   localparam cmd_type CMD_PRESET_RCL   = 5'h0c;
   localparam cmd_type CMD_PRESET_STO   = 5'h0d; // preset_store_cmd
   localparam cmd_type CMD_SETUP_RCL    = 5'h0e; // setup_recall_cmd
   localparam cmd_type CMD_SETUP_STO    = 5'h0f; // setup_store_cmd
   localparam cmd_type CMD_FACTORY      = 5'h10; // factory_default_cmd
   localparam cmd_type CMD_ALARM_RESET  = 5'h11;
   localparam cmd_type CMD_POS_VLIM     = 5'h12; // pos_voltage_limit_cmd
   localparam cmd_type CMD_NEG_VLIM     = 5'h13; // neg_voltage_limit_cmd
   localparam cmd_type CMD_POS_ILIM     = 5'h14; // pos_current_limit_cmd
   localparam cmd_type CMD_NEG_ILIM     = 5'h15; // neg_current_limit_cmd
   localparam cmd_type CMD_HW_POS_VLIM  = 5'h16; // hw_pos_voltage_query
   localparam cmd_type CMD_HW_NEG_VLIM  = 5'h17; // hw_neg_voltage_query
   localparam cmd_type CMD_HW_POS_ILIM  = 5'h18; // hw_pos_current_query
   localparam cmd_type CMD_HW_NEG_ILIM  = 5'h19; // hw_neg_current_query
   localparam cmd_type CMD_LIMIT_ACTION = 5'h1a; // limit_action_cmd
   localparam cmd_type CMD_OVP_MODE     = 5'h1b; // overvoltage_mode_cmd
   localparam cmd_type CMD_LIMIT_DELAY  = 5'h1c; // limit_delay_cmd
   localparam cmd_type CMD_BUS_PROT     = 5'h1d; // bus_protection_cmd

   // Argument ranges
   localparam int FINE_MIN      = -128;
   localparam int FINE_MAX      = 127;
   localparam int SLEW_MIN      = 1;
   localparam int SLEW_MAX      = 4;
   localparam int PRESET_MIN    = 1;
   localparam int PRESET_MAX    = 4;
   localparam int SETUP_MIN     = 0;
   localparam int SETUP_MAX     = 9;
   localparam int NUM_PRESETS   = 4;
   localparam int NUM_SETUPS    = 10;

   // Codes of the coded settings
   localparam logic [2:0] SLEW_FAST    = 3'h1;
   localparam logic [2:0] SLEW_MID     = 3'h2;
   localparam logic [2:0] SLEW_SLOW    = 3'h3;
   localparam logic [2:0] SLEW_NONE    = 3'h4;
   localparam logic [1:0] ACT_OUT_OFF  = 2'h1;
   localparam logic [1:0] ACT_PWR_OFF  = 2'h2;
   localparam int         OVP_MIN      = 1;
   localparam int         OVP_MAX      = 3;
   localparam int         OVP_CROWBAR  = 4;
   localparam logic [1:0] BUS_PROT_OFF = 2'h1;
   localparam logic [1:0] BUS_PROT_ON  = 2'h2;

   // Slew times in microseconds, zero meaning no limiting
   localparam logic [12:0] SLEW_FAST_US    = 13'd50;
   localparam logic [12:0] SLEW_FAST_CC_US = 13'd100;
   localparam logic [12:0] SLEW_MID_US     = 13'd500;
   localparam logic [12:0] SLEW_SLOW_US    = 13'd5000;
   localparam logic [12:0] SLEW_NONE_US    = 13'h0000;

   // Limit delay, held in steps of 10 ms
   localparam int LIM_DLY_STEP_MS = 10;
   localparam int LIM_DLY_MIN_MS  = 50;
   localparam int LIM_DLY_MAX_MS  = 9990;
   localparam int LIM_DLY_MIN     = LIM_DLY_MIN_MS / LIM_DLY_STEP_MS;
   localparam int LIM_DLY_MAX     = LIM_DLY_MAX_MS / LIM_DLY_STEP_MS;

   // Error codes on the answer port
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_CANT_EXEC = 8'h3d; // 61 decimal
   localparam logic [7:0] ERR_REFUSED   = 8'h32;

   // One complete setup, the unit saved in a setup file
   typedef struct packed {
      val_type     v_set;
      val_type     i_set;
      logic signed [7:0] fine_v;
      logic signed [7:0] fine_i;
      logic [2:0]  slew;
      val_type     pos_vlim;
      val_type     neg_vlim;
      val_type     pos_ilim;
      val_type     neg_ilim;
      logic [1:0]  lim_act;
      logic [1:0]  ovp;
      logic [9:0]  delay;
      logic [1:0]  bus_prot;
   } setup_type;

   localparam setup_type FACTORY_SETUP = '{
      v_set: 16'h0000, i_set: 16'h0000, fine_v: 8'h00, fine_i: 8'h00, slew: SLEW_NONE,
      pos_vlim: 16'h7fff, neg_vlim: 16'h8000, pos_ilim: 16'h7fff, neg_ilim: 16'h8000,
      lim_act: ACT_OUT_OFF, ovp: 2'h1, delay: 10'h005, bus_prot: BUS_PROT_OFF};

endpackage

// ===== supply_host.sv
// Host model: sends one program or query message per call.
// Assumes the interpreter answers in the cycle after the strobe.
`timescale 1ns/10ps
module supply_host
   import supply_cmd_pkg::*;
(
   input  wire logic    clock_i,
   input  wire val_type rdata_i,
   input  wire logic    err_i,
   output cmd_type      addr_o = 5'h0,
   output val_type      wdata_o = 16'h0,
   output logic         wr_o = 1'b0,
   output logic         rd_o = 1'b0
);
   // One strobe cycle, then take the answer
   task automatic cmd(input logic w, input cmd_type a, input val_type d, output val_type q, output logic e);
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      rd_o <= !w;
      @(posedge clock_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      #1;
      q = rdata_i;
      e = err_i;
   endtask
endmodule

// ===== supply_cmd_chk.sv
// Checker: command port and setting outputs of the interpreter.
// Assumes mode and limit inputs change slowly against the clock.
`timescale 1ns/10ps
module supply_cmd_chk
   import supply_cmd_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_b_i,
   input wire logic [4:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic        cc_mode_i,
   input wire logic        limit_event_i,
   input wire logic        err_o,
   input wire logic [7:0]  err_code_o,
   input wire logic        out_en_o,
   input wire logic        alarm_o,
   input wire logic [15:0] v_set_o,
   input wire logic [7:0]  fine_v_o,
   input wire logic [7:0]  fine_i_o,
   input wire logic [1:0]  ovp_mode_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // A program message with a given code
   sequence s_wr(cmd_type c); wr_i && addr_i == c; endsequence
   property p_on; !limit_event_i [*4] ##0 s_wr(CMD_OUTPUT) ##0 wdata_i == 16'h1 |=> out_en_o; endproperty
   a_on: assert property (p_on) else $error("output stays off");
   property p_voltage_setpoint_cmd; s_wr(CMD_VOLT_SET) |=> v_set_o == $past(wdata_i); endproperty
   a_voltage_setpoint_cmd: assert property (p_voltage_setpoint_cmd) else $error("voltage setpoint lost");
   property p_fcc; cc_mode_i [*4] ##0 s_wr(CMD_FINE_VOLT) |=> err_o && $stable(fine_v_o); endproperty
   a_fcc: assert property (p_fcc) else $error("fine voltage taken in cc");
   property p_fcv; !cc_mode_i [*4] ##0 s_wr(CMD_FINE_CURR) |=> err_o && $stable(fine_i_o); endproperty
   a_fcv: assert property (p_fcv) else $error("fine current taken in cv");
   property p_trig; !cc_mode_i [*4] ##0 s_wr(CMD_BUF_VOLT) ##1 (!wr_i && !rd_i) ##1 s_wr(CMD_BUF_EXEC)
      |=> v_set_o == $past(wdata_i, 3);
   endproperty
   a_trig: assert property (p_trig) else $error("buffered voltage not applied");
   property p_ovp; s_wr(CMD_OVP_MODE) ##0 wdata_i == 16'h4 |=> err_o && err_code_o == ERR_CANT_EXEC && $stable(ovp_mode_o);
   endproperty
   a_ovp: assert property (p_ovp) else $error("crowbar code accepted");
   property p_alm; $rose(limit_event_i) |-> ##[2:4] alarm_o; endproperty
   a_alm: assert property (p_alm) else $error("no alarm on limit event");
   property p_clr; !limit_event_i [*4] ##0 s_wr(CMD_ALARM_RESET) |=> !alarm_o; endproperty
   a_clr: assert property (p_clr) else $error("alarm not reset");
endmodule
bind supply_cmd supply_cmd_chk u_chk (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .cc_mode_i, .limit_event_i,
   .err_o, .err_code_o, .out_en_o, .alarm_o, .v_set_o, .fine_v_o, .fine_i_o, .ovp_mode_o);

// ===== supply_cmd_tb.sv
// Testbench: host model on the command port, analog inputs driven here.
// Assumes the checker is bound to the interpreter.
`timescale 1ns/10ps
module supply_cmd_tb
   import supply_cmd_pkg::*;
;
   logic        clock_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        cc = 1'b0;
   logic        lim = 1'b0;
   logic        wr, rd, err, out_en, pwr_off, alarm, bus_en;
   cmd_type     addr;
   logic [7:0]  err_code, fine_v, fine_i;
   logic [12:0] slew;
   logic [15:0] wdata, rdata, v_set, i_set;
   logic [15:0] pvl, nvl, pil, nil;
   logic [1:0]  ovp;
   logic [9:0]  dly;
   logic [15:0] hw = 16'h0444;
   logic [12:0] slew_tbl [4] = '{SLEW_FAST_US, SLEW_MID_US, SLEW_SLOW_US, SLEW_NONE_US};
   int          bad_count = 0;
   int          n_tests = 0;
   // Clock of 50 ns period
   always #25 clock_i = !clock_i;
   supply_host u_supply_host (.clock_i, .rdata_i(rdata), .err_i(err), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd));
   supply_cmd u_supply_cmd (.clock_i, .rst_b_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .cc_mode_i(cc),
      .limit_event_i(lim), .meas_v_i(hw - 16'h1), .meas_i_i(~hw), .hw_pos_vlim_i(hw), .hw_neg_vlim_i(hw + 16'h1),
      .hw_pos_ilim_i(hw + 16'h2), .hw_neg_ilim_i(hw + 16'h3), .rdata_o(rdata), .err_o(err), .err_code_o(err_code),
      .out_en_o(out_en), .power_off_o(pwr_off), .alarm_o(alarm), .v_set_o(v_set), .i_set_o(i_set), .fine_v_o(fine_v),
      .fine_i_o(fine_i), .slew_us_o(slew), .pos_vlim_o(pvl), .neg_vlim_o(nvl), .pos_ilim_o(pil), .neg_ilim_o(nil),
      .ovp_mode_o(ovp), .limit_delay_o(dly), .bus_prot_en_o(bus_en));
   // Compare and count
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Program message with its expected error flag
   task automatic w(input cmd_type a, input val_type d, input logic e);
      val_type q;
      logic    f;
      u_supply_host.cmd(1'b1, a, d, q, f);
      ck(f, e);
   endtask
   // Query message with its expected answer
   task automatic r(input cmd_type a, input val_type x);
      val_type q;
      logic    f;
      u_supply_host.cmd(1'b0, a, 16'h0, q, f);
      ck(q, x);
   endtask
   // Mode change, held past the synchronisers
   task automatic mode(input logic c);
      @(posedge clock_i);
      cc <= c;
      repeat (4) @(posedge clock_i);
   endtask
   task automatic t_basic;
      w(CMD_OUTPUT, 16'h1, 1'b0);
      r(CMD_OUTPUT, 16'h1);
      w(CMD_OUTPUT, 16'h2, 1'b1);
      w(CMD_OUTPUT, 16'h0, 1'b0);
      ck(out_en, 1'b0);
      w(CMD_CURR_SET, 16'h8001, 1'b0);
      r(CMD_CURR_SET, 16'h8001);
      r(CMD_VOLT_MEAS, hw - 16'h1);
      r(CMD_CURR_MEAS, ~hw);
      for (int i = 0; i < 4; i++) r(CMD_HW_POS_VLIM + 5'(i), hw + 16'(i));
      w(CMD_HW_POS_VLIM, 16'h1, 1'b1);
   endtask
   task automatic t_codes;
      for (int i = 1; i <= 4; i++) begin
         w(CMD_SLEW_TIME, 16'(i), 1'b0);
         ck(slew, slew_tbl[i-1]);
         w(CMD_OVP_MODE, 16'(i), i == 4);
         ck(err_code, (i == 4) ? ERR_CANT_EXEC : ERR_NONE);
         w(CMD_POS_VLIM + 5'(i-1), 16'(i * 99), 1'b0);
         r(CMD_POS_VLIM + 5'(i-1), 16'(i * 99));
      end
      ck(pvl, 16'h0063);
      ck(nvl, 16'h00c6);
      ck(pil, 16'h0129);
      ck(nil, 16'h018c);
      r(CMD_OVP_MODE, 16'h3);
      ck(ovp, 2'h3);
      for (int i = 1; i <= 3; i++) w(CMD_BUS_PROT, 16'(i), i == 3);
      ck(bus_en, 1'b1);
      w(CMD_LIMIT_DELAY, 16'h4, 1'b1);
      w(CMD_LIMIT_DELAY, 16'd999, 1'b0);
      r(CMD_LIMIT_DELAY, 16'd999);
      ck(dly, 10'h3e7);
   endtask
   task automatic t_trigger;
      w(CMD_FINE_VOLT, 16'hff80, 1'b0);
      r(CMD_FINE_VOLT, 16'hff80);
      w(CMD_FINE_CURR, 16'h5, 1'b1);
      w(CMD_BUF_VOLT, 16'h321, 1'b0);
      w(CMD_BUF_EXEC, 16'h0, 1'b0);
      ck(v_set, 16'h321);
      ck(fine_v, 8'h80);
      w(CMD_VOLT_SET, 16'h1, 1'b0);
      w(CMD_BUF_EXEC, 16'h0, 1'b0);
      w(CMD_BUF_VOLT, 16'h222, 1'b0);
      w(CMD_BUF_CLEAR, 16'h0, 1'b0);
      w(CMD_BUF_EXEC, 16'h0, 1'b0);
      w(CMD_BUF_VOLT, 16'h333, 1'b0);
      r(CMD_VOLT_SET, 16'h1);
      w(CMD_BUF_EXEC, 16'h0, 1'b0);
      ck(v_set, 16'h1);
      mode(1'b1);
      w(CMD_SLEW_TIME, 16'h1, 1'b0);
      ck(slew, SLEW_FAST_CC_US);
      w(CMD_BUF_VOLT, 16'h55, 1'b1);
      w(CMD_FINE_VOLT, 16'h1, 1'b1);
      w(CMD_FINE_CURR, 16'h7f, 1'b0);
      w(CMD_BUF_CURR, 16'h44, 1'b0);
      w(CMD_BUF_EXEC, 16'h0, 1'b0);
      ck(i_set, 16'h44);
      mode(1'b0);
      w(CMD_BUF_CURR, 16'h66, 1'b1);
   endtask
   task automatic t_memory;
      w(CMD_VOLT_SET, 16'haaa, 1'b0);
      w(CMD_PRESET_STO, 16'h4, 1'b0);
      w(CMD_PRESET_STO, 16'h5, 1'b1);
      w(CMD_VOLT_SET, 16'hbbb, 1'b0);
      w(CMD_SETUP_STO, 16'h9, 1'b0);
      w(CMD_PRESET_RCL, 16'h4, 1'b0);
      ck(v_set, 16'haaa);
      w(CMD_FACTORY, 16'h0, 1'b0);
      ck(slew, SLEW_NONE_US);
      w(CMD_SETUP_RCL, 16'h9, 1'b0);
      ck(v_set, 16'hbbb);
      ck(fine_i, 8'h7f);
   endtask
   // Raise a limit event and wait for the alarm
   task automatic rise;
      @(posedge clock_i);
      lim <= 1'b1;
      for (int k = 0; k < 8 && alarm !== 1'b1; k++) begin
         @(posedge clock_i);
         #1;
      end
      ck(alarm, 1'b1);
      if (alarm !== 1'b1) finish_test();
      @(posedge clock_i);
      lim <= 1'b0;
      repeat (5) @(posedge clock_i);
   endtask
   task automatic t_limit;
      w(CMD_LIMIT_ACTION, 16'h1, 1'b0);
      w(CMD_OUTPUT, 16'h1, 1'b0);
      rise();
      ck(out_en, 1'b0);
      w(CMD_ALARM_RESET, 16'h0, 1'b0);
      ck(alarm, 1'b0);
      w(CMD_LIMIT_ACTION, 16'h2, 1'b0);
      rise();
      ck(pwr_off, 1'b1);
   endtask
   task automatic finish_test;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Reset, then the scenarios
   initial begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_basic();
      t_codes();
      t_trigger();
      t_memory();
      t_limit();
      finish_test();
   end
endmodule
